// >>> hw/psit_pkg.sv
package psit_pkg;
    localparam int unsigned PERF_N = 4;
    localparam logic [7:0] IDX_SUMMARY = 8'h50;
    localparam logic [7:0] IDX_LIVE = 8'h52;
    localparam logic [7:0] IDX_LATCHED = 8'h54;
    localparam logic [7:0] IDX_IRQ_EN = 8'h56;
    localparam logic [7:0] IDX_CTRL = 8'h58;
    localparam logic [7:0] IDX_CLEAR = 8'h5a;
    localparam int unsigned SUM_PORT = 9;
    localparam int unsigned SUM_LINE = 8;
    localparam int unsigned SUM_TRAIL = 7;
    localparam int unsigned SUM_FEAC = 6;
    localparam int unsigned SUM_HDLC = 5;
    localparam int unsigned SUM_BERT = 4;
    localparam int unsigned SUM_FRAMER = 0;
    localparam int unsigned BIT_OVL = 2;
    localparam int unsigned BIT_LOL = 1;
    localparam int unsigned BIT_PMD = 0;
    localparam int unsigned BIT_RXCLK = 7;
    localparam int unsigned BIT_TXCLK = 6;
    localparam int unsigned CTRL_GIE = 0;
    localparam int unsigned CTRL_PMU = 1;
    localparam logic [15:0] LAT_MASK = 16'h00c7;
    localparam logic [15:0] EN_MASK = 16'h0007;
    localparam logic [15:0] CTRL_MASK = 16'h0003;
    localparam logic [15:0] REG_RST = 16'h0000;
    typedef struct packed {
        logic line_code;
        logic trail_trace;
        logic far_end_alarm;
        logic hdlc;
        logic bit_tester;
        logic ds3_framer;
        logic e3_framer;
    } psit_sub_type;
    typedef struct packed {
        logic tx_driver_overload;
        logic rx_lock_lost;
        logic perf_update_done;
    } psit_live_type;
endpackage

// >>> hw/psit_sticky.sv
`timescale 1ns/10ps
`default_nettype none
module psit_sticky
    import psit_pkg::*;
#(
    parameter int unsigned W = 16
) (
    input wire logic clk, // clock
    input wire logic rstn, // async reset
    input wire logic [W-1:0] set_evt, // event per bit
    input wire logic [W-1:0] clr, // write-one clear per bit
    output logic [W-1:0] q // sticky bits
);
    logic [W-1:0] q_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            // a set in the clearing cycle wins
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    q_r[i] <= 1'b0;
                end else begin
                    q_r[i] <= set_evt[i] | (q_r[i] & ~clr[i]);
                end
            end
        end
    endgenerate

    assign q = q_r;
endmodule
`default_nettype wire

// >>> hw/psit_top.sv
`timescale 1ns/10ps
`default_nettype none
module psit_top
    import psit_pkg::*;
(
    input wire logic clk, // 200 MHz clock
    input wire logic rstn, // async reset
    input wire logic [7:0] avs_address, // word index
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte lanes
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    input wire logic tx_driver_overload, // driver monitor level
    input wire logic rx_lock_lost, // recovery loop unlocked
    input wire logic [PERF_N-1:0] perf_done, // per-source update done
    input wire logic [PERF_N-1:0] perf_active, // source takes part
    input wire logic rx_line_clock_pin, // receive line clock
    input wire logic rx_recovered_clock, // recovered clock
    input wire logic tx_input_clock_pin, // transmit input clock
    input wire psit_sub_type sub_pending, // sub-block pending
    input wire logic framer_is_e3, // active framer select
    output logic perf_update_request, // update request level
    output logic irq // interrupt level
);
    logic req;
    logic ack_r;
    logic wr_go;
    logic [15:0] wdata;
    logic lo_we;
    logic hi_we;
    logic [15:0] en_r;
    logic [15:0] ctrl_r;
    logic [15:0] lat_q;
    logic [15:0] lat_set;
    logic [15:0] lat_clr;
    psit_live_type live_nxt;
    psit_live_type live_r;
    logic rxclk_d_r;
    logic recclk_d_r;
    logic txclk_d_r;
    logic [15:0] sum_nxt;
    logic [15:0] sum_r;
    logic irq_r;
    logic [15:0] rd_val;
    logic [31:0] rdata_r;

    // bus: one wait cycle, then the answer
    assign req = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_r;
    assign wr_go = avs_write & ack_r;
    assign wdata = avs_writedata[15:0];
    assign lo_we = wr_go & avs_byteenable[0];
    assign hi_we = wr_go & avs_byteenable[1];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req & ~ack_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            en_r <= REG_RST;
        end else if (lo_we && avs_address == IDX_IRQ_EN) begin
            en_r <= wdata & EN_MASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= REG_RST;
        end else if (lo_we && avs_address == IDX_CTRL) begin
            ctrl_r <= wdata & CTRL_MASK;
        end
    end

    // host keeps request high until update done is seen
    assign perf_update_request = ctrl_r[CTRL_PMU];

    // live status
    always_comb begin
        live_nxt.tx_driver_overload = tx_driver_overload;
        live_nxt.rx_lock_lost = rx_lock_lost;
        live_nxt.perf_update_done = &(perf_done | ~perf_active);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            live_r <= '0;
        end else begin
            live_r <= live_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxclk_d_r <= 1'b0;
            recclk_d_r <= 1'b0;
            txclk_d_r <= 1'b0;
        end else begin
            rxclk_d_r <= rx_line_clock_pin;
            recclk_d_r <= rx_recovered_clock;
            txclk_d_r <= tx_input_clock_pin;
        end
    end

    // latched events: rising edges of live bits, toggles of clocks
    always_comb begin
        lat_set = 16'h0000;
        lat_set[BIT_RXCLK] = (rx_line_clock_pin ^ rxclk_d_r)
            | (rx_recovered_clock ^ recclk_d_r);
        lat_set[BIT_TXCLK] = tx_input_clock_pin ^ txclk_d_r;
        lat_set[BIT_OVL] = live_nxt.tx_driver_overload
            & ~live_r.tx_driver_overload;
        lat_set[BIT_LOL] = live_nxt.rx_lock_lost & ~live_r.rx_lock_lost;
        lat_set[BIT_PMD] = live_nxt.perf_update_done
            & ~live_r.perf_update_done;
    end

    // write one clears, through the latched or the clear register
    assign lat_clr = (lo_we && (avs_address == IDX_LATCHED || avs_address == IDX_CLEAR))
        ? (wdata & LAT_MASK) : 16'h0000;

    psit_sticky #(
        .W(16)
    ) u_lat (
        .clk(clk),
        .rstn(rstn),
        .set_evt(lat_set),
        .clr(lat_clr),
        .q(lat_q)
    );

    // summary follows its sources and clears by itself
    always_comb begin
        sum_nxt = 16'h0000;
        sum_nxt[SUM_PORT] = |(lat_q & en_r);
        sum_nxt[SUM_LINE] = sub_pending.line_code;
        sum_nxt[SUM_TRAIL] = sub_pending.trail_trace;
        sum_nxt[SUM_FEAC] = sub_pending.far_end_alarm;
        sum_nxt[SUM_HDLC] = sub_pending.hdlc;
        sum_nxt[SUM_BERT] = sub_pending.bit_tester;
        sum_nxt[SUM_FRAMER] = framer_is_e3 ? sub_pending.e3_framer
            : sub_pending.ds3_framer;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sum_r <= REG_RST;
        end else begin
            sum_r <= sum_nxt;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= (|sum_nxt) & ctrl_r[CTRL_GIE];
        end
    end

    assign irq = irq_r;

    always_comb begin
        case (avs_address)
            IDX_SUMMARY: rd_val = sum_r;
            IDX_LIVE: rd_val = {13'h0, live_r};
            IDX_LATCHED: rd_val = lat_q;
            IDX_IRQ_EN: rd_val = en_r;
            IDX_CTRL: rd_val = ctrl_r;
            default: rd_val = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            rdata_r <= {16'h0000, rd_val};
        end
    end

    assign avs_readdata = rdata_r;

    // upper byte has no writable bits
    logic hi_unused;
    assign hi_unused = hi_we;

    port_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_PORT] == $past(|(lat_q & en_r)))
        else $error("port summary bit wrong");

    line_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_LINE] == $past(sub_pending.line_code))
        else $error("line code summary wrong");

    trail_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_TRAIL] == $past(sub_pending.trail_trace))
        else $error("trail trace summary wrong");

    feac_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_FEAC] == $past(sub_pending.far_end_alarm))
        else $error("far-end alarm summary wrong");

    hdlc_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_HDLC] == $past(sub_pending.hdlc))
        else $error("hdlc summary wrong");

    bert_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_BERT] == $past(sub_pending.bit_tester))
        else $error("bit tester summary wrong");

    framer_sum_a: assert property (@(posedge clk) disable iff (!rstn)
        sum_r[SUM_FRAMER] == ($past(framer_is_e3) ? $past(sub_pending.e3_framer)
            : $past(sub_pending.ds3_framer)) && sum_r[3:1] == 3'h0)
        else $error("framer summary wrong");

    irq_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        irq == ((|$past(sum_nxt)) && $past(ctrl_r[CTRL_GIE])))
        else $error("interrupt pin wrong");

    overload_live_a: assert property (@(posedge clk) disable iff (!rstn)
        live_r.tx_driver_overload == $past(tx_driver_overload))
        else $error("overload live bit wrong");

    lock_live_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(rx_lock_lost) |=> live_r.rx_lock_lost)
        else $error("loss of lock live bit missed");

    perf_and_a: assert property (@(posedge clk) disable iff (!rstn)
        (|(perf_active & ~perf_done)) |=> !live_r.perf_update_done)
        else $error("update done high too early");

    rxclk_act_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(rx_line_clock_pin) |-> ##1 lat_q[BIT_RXCLK])
        else $error("rx clock activity not latched");

    txclk_act_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(tx_input_clock_pin) |-> ##1 lat_q[BIT_TXCLK])
        else $error("tx clock activity not latched");

    edge_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(live_r.rx_lock_lost) |-> lat_q[BIT_LOL])
        else $error("loss of lock edge not latched");

    en_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (en_r == 16'h0000) |=> !sum_r[SUM_PORT])
        else $error("disabled bit raised summary");

    gie_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        !ctrl_r[CTRL_GIE] |=> !irq)
        else $error("pin driven without global enable");

    w1c_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (lat_clr[BIT_OVL] && !lat_set[BIT_OVL]) |=> !lat_q[BIT_OVL])
        else $error("latched bit not cleared");

    ovl_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(live_r.tx_driver_overload) |-> lat_q[BIT_OVL])
        else $error("overload edge not latched");

    pmd_latch_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(live_r.perf_update_done) |-> lat_q[BIT_PMD])
        else $error("update done edge not latched");

    rec_act_a: assert property (@(posedge clk) disable iff (!rstn)
        $changed(rx_recovered_clock) |-> ##1 lat_q[BIT_RXCLK])
        else $error("recovered clock activity not latched");

    lat_resv_a: assert property (@(posedge clk) disable iff (!rstn)
        (lat_q & ~LAT_MASK) == 16'h0000)
        else $error("reserved latched bit set");

    en_resv_a: assert property (@(posedge clk) disable iff (!rstn)
        (en_r & ~EN_MASK) == 16'h0000)
        else $error("reserved enable bit set");

    sum_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        !(|(lat_q & en_r)) |=> !sum_r[SUM_PORT])
        else $error("port summary did not clear");
endmodule
`default_nettype wire

// >>> tb/psit_host.sv
`timescale 1ns/10ps
`default_nettype none
module psit_host
    import psit_pkg::*;
(
    input wire logic clk, // clock
    output logic [7:0] avs_address, // word index
    output logic avs_read, // read request
    output logic avs_write, // write request
    output logic [31:0] avs_writedata, // write data
    output logic [3:0] avs_byteenable, // byte lanes
    input wire logic [31:0] avs_readdata, // read data
    input wire logic avs_waitrequest // stall
);
    logic tmo = 1'b0;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
    end
    // one bus cycle, held until waitrequest is seen low; a spare edge before the next
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        int n;
        n = 0;
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= 4'hf;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 40);
        tmo = tmo | (avs_waitrequest !== 1'b0);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    // request held until done reads high or 30 reads pass, then dropped
    task automatic perf_update(output logic ok);
        logic [15:0] q;
        xfer(1'b1, IDX_CTRL, 16'h0002, q);
        ok = 1'b0;
        for (int n = 0; n < 30 && !ok; n++) begin
            xfer(1'b0, IDX_LIVE, 16'h0000, q);
            ok = (q[0] === 1'b1);
        end
        xfer(1'b1, IDX_CTRL, 16'h0000, q);
    endtask
endmodule
`default_nettype wire

// >>> tb/port_status_interrupt_tree_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module port_status_interrupt_tree_tb_top
    import psit_pkg::*;
;
    logic clk = 1'b0;
    logic rstn, avs_read, avs_write, avs_waitrequest, perf_update_request, irq, framer_is_e3;
    logic tx_driver_overload, rx_lock_lost, rx_line_clock_pin, rx_recovered_clock, tx_input_clock_pin;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable, perf_done, perf_active;
    psit_sub_type sub_pending;
    int n_fail = 0;
    int n_compared = 0;
    logic [7:0] amap [7] = '{8'h40, IDX_SUMMARY, IDX_LIVE, IDX_LATCHED, IDX_IRQ_EN, IDX_CTRL, IDX_CLEAR};
    always #2.5 clk = ~clk;
    psit_top dut (.clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .tx_driver_overload, .rx_lock_lost, .perf_done, .perf_active,
        .rx_line_clock_pin, .rx_recovered_clock, .tx_input_clock_pin, .sub_pending, .framer_is_e3,
        .perf_update_request, .irq);
    psit_host host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest);
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        host.xfer(1'b0, a, 16'h0, q);
        if (host.tmo) begin
            n_fail++;
            end_sim();
        end
        chk(q, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        host.xfer(1'b1, a, d, q);
        if (host.tmo) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic set3(input logic [2:0] v, input logic pins);
        @(posedge clk);
        if (pins) begin
            {rx_line_clock_pin, rx_recovered_clock, tx_input_clock_pin} <= v;
        end else begin
            {tx_driver_overload, rx_lock_lost, perf_done[0]} <= v;
        end
        @(posedge clk);
    endtask
    function automatic logic [15:0] exp_live(input logic [15:0] r);
        exp_live = {13'h0, r[0], r[1], &(r[5:2] | ~r[9:6])};
    endfunction
    function automatic logic [15:0] exp_sum(input psit_sub_type s, input logic e3);
        exp_sum = 16'h0;
        exp_sum[8] = s.line_code;
        exp_sum[7] = s.trail_trace;
        exp_sum[6] = s.far_end_alarm;
        exp_sum[5] = s.hdlc;
        exp_sum[4] = s.bit_tester;
        exp_sum[0] = e3 ? s.e3_framer : s.ds3_framer;
    endfunction
    initial begin
        logic [15:0] r;
        logic ok;
        rstn = 1'b0;
        {tx_driver_overload, rx_lock_lost, framer_is_e3} = 3'h0;
        {rx_line_clock_pin, rx_recovered_clock, tx_input_clock_pin} = 3'h0;
        perf_done = 4'h0;
        perf_active = 4'h1;
        sub_pending = '0;
        void'($urandom(32'hf3fc63f0));
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (amap[i]) rd(amap[i], 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr(amap[i], 16'hffff);
            rd(amap[i], 16'h0000);
        end
        for (int i = 0; i < 4; i++) begin
            r = 16'($urandom);
            wr(IDX_IRQ_EN, r);
            rd(IDX_IRQ_EN, r & EN_MASK);
            wr(IDX_CTRL, r);
            chk({15'h0, perf_update_request}, {15'h0, r[CTRL_PMU]});
        end
        wr(IDX_CTRL, 16'h0001);
        wr(IDX_IRQ_EN, 16'h0000);
        $display("register test done");
        for (int i = 0; i < 8; i++) begin
            r = (i == 0) ? 16'h0000 : 16'($urandom);
            @(posedge clk);
            {perf_active, perf_done, rx_lock_lost, tx_driver_overload} <= r[9:0];
            @(posedge clk);
            rd(IDX_LIVE, exp_live(r));
        end
        @(posedge clk);
        perf_active <= 4'h1;
        set3(3'h0, 1'b0);
        wr(IDX_LATCHED, 16'hffff);
        for (int b = 0; b < 3; b++) begin
            set3(3'(1 << b), 1'b0);
            rd(IDX_LATCHED, 16'(1 << b));
            wr(IDX_LATCHED, 16'hffff);
            rd(IDX_LATCHED, 16'h0000);
        end
        for (int c = 0; c < 3; c++) begin
            set3(3'(1 << c), 1'b1);
            set3(3'h0, 1'b1);
            rd(IDX_LATCHED, (c == 0) ? 16'h0040 : 16'h0080);
            wr(IDX_CLEAR, 16'hffff);
            rd(IDX_LATCHED, 16'h0000);
        end
        $display("status test done");
        set3(3'h0, 1'b0);
        set3(3'h7, 1'b0);
        for (int e = 0; e < 3; e++) begin
            wr(IDX_IRQ_EN, 16'(1 << e));
            rd(IDX_SUMMARY, 16'h0200);
            chk({15'h0, irq}, 16'h0001);
        end
        wr(IDX_IRQ_EN, 16'h0000);
        rd(IDX_SUMMARY, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        wr(IDX_IRQ_EN, 16'h0007);
        wr(IDX_CLEAR, 16'hffff);
        rd(IDX_SUMMARY, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        for (int i = 0; i < 14; i++) begin
            r = (i < 7) ? 16'(1 << i) : (i == 7) ? 16'h0181 : 16'($urandom);
            @(posedge clk);
            sub_pending <= psit_sub_type'(r[6:0]);
            framer_is_e3 <= r[7];
            wr(IDX_CTRL, {15'h0, r[8]});
            rd(IDX_SUMMARY, exp_sum(psit_sub_type'(r[6:0]), r[7]));
            chk({15'h0, irq}, {15'h0, r[8] & (|exp_sum(psit_sub_type'(r[6:0]), r[7]))});
        end
        $display("summary test done");
        @(posedge clk);
        sub_pending <= '0;
        perf_active <= 4'h3;
        perf_done <= 4'h0;
        @(posedge clk);
        wr(IDX_CLEAR, 16'hffff);
        fork
            host.perf_update(ok);
            begin
                repeat (30) @(posedge clk);
                perf_done <= 4'h3;
            end
        join
        if (host.tmo) begin
            n_fail++;
            end_sim();
        end
        chk({15'h0, ok}, 16'h0001);
        chk({15'h0, perf_update_request}, 16'h0000);
        rd(IDX_LATCHED, 16'h0001);
        $display("update test done");
        end_sim();
    end
endmodule
`default_nettype wire
